//--- verilog/sar_adc_pkg.sv
// Package: register map, field layout, reset values and timing for the converter sequencer
package sar_adc_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
   localparam logic [3:0] RESULT_OFFSET         = 4'h4;
   localparam logic [3:0] CLOCK_CONFIG_OFFSET   = 4'h8;
   localparam logic [3:0] PORT_DATA_OFFSET      = 4'hC;

   // Status/control field positions
   localparam int DONE_ROUTE_BIT    = 7;
   localparam int IRQ_ENABLE_BIT    = 6;
   localparam int CONTINUOUS_BIT    = 5;
   localparam int CHANNEL_LSB       = 0;
   localparam int CHANNEL_WIDTH     = 5;

   // Clock config field positions
   localparam int CLOCK_DIVIDE_LSB  = 5;
   localparam int CLOCK_SOURCE_BIT  = 4;

   // Reset values
   localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1F;
   localparam logic [7:0] CLOCK_CONFIG_RESET   = 8'h00;
   localparam logic [7:0] RESULT_RESET         = 8'h00;

   // Channel codes
   localparam logic [4:0] LAST_EXTERNAL_CHANNEL = 5'h05;
   localparam logic [4:0] HIGH_REF_CHANNEL      = 5'h1D;
   localparam logic [4:0] LOW_REF_CHANNEL       = 5'h1E;
   localparam logic [4:0] POWER_OFF_CHANNEL     = 5'h1F;
   localparam int         EXTERNAL_CHANNELS     = 6;

   // Conversion length in converter clock ticks
   localparam logic [4:0] CONVERSION_TICKS      = 5'h10;
   localparam int         SAR_BITS              = 8;

   // Result codes at the references
   localparam logic [7:0] FULL_SCALE_CODE = 8'hFF;
   localparam logic [7:0] ZERO_SCALE_CODE = 8'h00;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE    = 2'b00,
      SEQ_CONVERT = 2'b01,
      SEQ_OFF     = 2'b10
   } seq_state_type;

endpackage

//--- verilog/adc_clock_divider.sv
// Converter clock tick generator: source select and divide by 1 to 16
`timescale 1ns/1ps
module adc_clock_divider
   import sar_adc_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Configuration
   input  wire logic [2:0] converterClockDivide,
   input  wire logic       converterClockSource,
   input  wire logic       oscillatorTick,
   input  wire logic       restart,
   // Tick out
   output logic            adcTick
);

   logic [3:0] divCount_r;
   logic [3:0] divLimit;
   logic       inputTick;

   // Bus clock when source is 1, oscillator ticks when 0
   assign inputTick = converterClockSource ? 1'b1 : oscillatorTick;

   // Top bit set forces divide by 16
   always_comb begin
      if (converterClockDivide[2]) begin
         divLimit = 4'hF;
      end else begin
         unique case (converterClockDivide[1:0])
            2'b00: divLimit = 4'h0;
            2'b01: divLimit = 4'h1;
            2'b10: divLimit = 4'h3;
            2'b11: divLimit = 4'h7;
         endcase
      end
   end

   // Divider counts input ticks; restart realigns phase to a fresh start
   always_ff @(posedge mclk) begin
      if (sys_rst || restart) begin
         divCount_r <= 4'h0;
         adcTick    <= 1'b0;
      end else if (inputTick) begin
         if (divCount_r >= divLimit) begin
            divCount_r <= 4'h0;
            adcTick    <= 1'b1;
         end else begin
            divCount_r <= divCount_r + 4'h1;
            adcTick    <= 1'b0;
         end
      end else begin
         adcTick <= 1'b0;
      end
   end

endmodule

//--- verilog/sar_adc_sequencer.sv
// Successive-approximation converter sequencer with AXI4-Lite registers and pin override
// Contract
// - Control register write starts a conversion
// - Conversion completes in 16 or 17 converter clocks
// - Continuous mode overwrites result every conversion
// - Continuous mode restarts until bit cleared
// - Continuous flag stays set until write/read
// - Single mode: one conversion per write
// - Without interrupts, completion bit read-only flag
// - With interrupts, bit selects processor or DMA
// - Interrupt at end, dropped by read/write
// - Reset clears enable, continuous, completion bits
// - Five-bit channel field, six external inputs
// - All-ones channel code powers converter off
// - Selected pin forced input, others general-purpose (code releases the selected pin while in stop)
// - Port writes ignore the converter pin
// - Port read of converter pin gives zero
// - Codes FF high reference, 00 low
// - Runs in wait; interrupt wakes processor
// - Stop aborts conversion; resumes after stop
// - Channel codes decode externals and references
// - Prescaler divides by 1,2,4,8,16
// - Source bit picks bus or oscillator
// - Result register updated every completion
`timescale 1ns/1ps
module sar_adc_sequencer
   import sar_adc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // AXI4-Lite write address
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Converter clock source and low-power state
   input  wire logic        oscillatorTick,
   input  wire logic        stopMode,
   // Analog front end: comparator answer and trial code
   input  wire logic        comparatorHigh,
   output logic [7:0]       sarTrialCode,
   output logic [4:0]       muxSelect,
   output logic             analogPowerOn,
   // Shared analog pins
   input  wire logic [5:0]  sharedAnalogPinsIn,
   output logic [5:0]       sharedAnalogPinsOut,
   output logic [5:0]       sharedAnalogPinsOe,
   // Requests to processor and DMA
   output logic             convIrq,
   output logic             dmaRequest
);

   // Register state
   logic [7:0]    statusControl_r;
   logic          doneFlag_r;
   logic [7:0]    result_r;
   logic [7:0]    clockConfig_r;
   logic [5:0]    portData_r;
   logic [5:0]    portDir_r;
   seq_state_type state_r;
   logic [4:0]    tickCount_r;
   logic          firstDone_r;
   logic          irqPending_r;
   // AXI handshake state
   logic          awHeld_r;
   logic          wHeld_r;
   logic [3:0]    awAddr_r;
   logic [31:0]   wData_r;
   logic [3:0]    wStrb_r;
   // Decoded fields and events
   logic       irqEnable;
   logic       continuous;
   logic [4:0] channel;
   logic       powerOff;
   logic       externalSel;
   logic       writeFire;
   logic       ctrlWrite;
   logic       resultRead;
   logic       adcTick;
   logic       convDone;
   logic [7:0] trialBit;
   logic [5:0] pinOwned;

   assign irqEnable  = statusControl_r[IRQ_ENABLE_BIT];
   assign continuous = statusControl_r[CONTINUOUS_BIT];
   assign channel    = statusControl_r[CHANNEL_LSB +: CHANNEL_WIDTH];
   assign powerOff   = (channel == POWER_OFF_CHANNEL);
   assign externalSel = (channel <= LAST_EXTERNAL_CHANNEL);

   // Write fires once address and data are both held and no response pending
   assign writeFire  = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign ctrlWrite  = writeFire && (awAddr_r == STATUS_CONTROL_OFFSET) && wStrb_r[0];
   assign resultRead = s_axi_arvalid && s_axi_arready && (s_axi_araddr == RESULT_OFFSET);

   // Converter clock tick; restarted on every control write for clean timing
   adc_clock_divider u_div (
      .mclk                 (mclk),
      .sys_rst              (sys_rst),
      .converterClockDivide (clockConfig_r[CLOCK_DIVIDE_LSB +: 3]),
      .converterClockSource (clockConfig_r[CLOCK_SOURCE_BIT]),
      .oscillatorTick       (oscillatorTick),
      .restart              (ctrlWrite),
      .adcTick              (adcTick)
   );

   // Last tick of a conversion
   assign convDone = (state_r == SEQ_CONVERT) && adcTick && !stopMode
                     && !ctrlWrite && (tickCount_r == CONVERSION_TICKS - 5'h1);

   // Write address and data accepted in either order
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= 4'h0;
         wData_r       <= 32'h00000000;
         wStrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end else if (writeFire) begin
            awHeld_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end else if (writeFire) begin
            wHeld_r <= 1'b0;
         end
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (writeFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr_r == RESULT_OFFSET || awAddr_r == STATUS_CONTROL_OFFSET
                          || awAddr_r == CLOCK_CONFIG_OFFSET || awAddr_r == PORT_DATA_OFFSET)
                         ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register; reset parks channel at power-off
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         statusControl_r <= STATUS_CONTROL_RESET;
      end else if (ctrlWrite) begin
         statusControl_r <= {1'b0, wData_r[6:0]};
      end
   end

   // Completion flag or route selector, depending on interrupt enable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         doneFlag_r <= 1'b0;
      end else if (ctrlWrite) begin
         // Writable selector only with interrupts on; otherwise write clears
         doneFlag_r <= wData_r[IRQ_ENABLE_BIT] ? wData_r[DONE_ROUTE_BIT] : 1'b0;
      end else if (!irqEnable) begin
         if (convDone && (!continuous || !firstDone_r)) begin
            doneFlag_r <= 1'b1;
         end else if (resultRead) begin
            doneFlag_r <= 1'b0;
         end
      end
   end

   // Interrupt request held until result read or control write; set wins
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irqPending_r <= 1'b0;
      end else if (convDone && irqEnable) begin
         irqPending_r <= 1'b1;
      end else if (ctrlWrite || resultRead) begin
         irqPending_r <= 1'b0;
      end
   end

   // Route request: selector 0 to processor, 1 to DMA; usable as wake source in wait
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         convIrq    <= 1'b0;
         dmaRequest <= 1'b0;
      end else begin
         convIrq    <= irqPending_r && irqEnable && !doneFlag_r;
         dmaRequest <= irqPending_r && irqEnable && doneFlag_r;
      end
   end

   // Sequencer: start on write, abort in stop, restart in continuous mode
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r     <= SEQ_OFF;
         tickCount_r <= 5'h00;
         firstDone_r <= 1'b0;
      end else if (ctrlWrite) begin
         // New settings restart from tick zero
         tickCount_r <= 5'h00;
         firstDone_r <= 1'b0;
         state_r     <= (wData_r[4:0] == POWER_OFF_CHANNEL) ? SEQ_OFF : SEQ_CONVERT;
      end else if (stopMode) begin
         // Abort; resume from scratch once stop ends
         tickCount_r <= 5'h00;
      end else begin
         unique case (state_r)
            SEQ_IDLE, SEQ_OFF: tickCount_r <= 5'h00;
            SEQ_CONVERT: begin
               if (convDone) begin
                  firstDone_r <= 1'b1;
                  tickCount_r <= 5'h00;
                  state_r     <= continuous ? SEQ_CONVERT : SEQ_IDLE;
               end else if (adcTick) begin
                  tickCount_r <= tickCount_r + 5'h01;
               end
            end
         endcase
      end
   end

   // One-hot trial bit from tick count, MSB first over ticks 0 to 7
   assign trialBit = (tickCount_r < 5'(SAR_BITS)) ? (8'h80 >> tickCount_r[2:0]) : 8'h00;

   // Approximation lives in the output flop so the comparator judges the current trial
   always_ff @(posedge mclk) begin
      if (sys_rst || ctrlWrite || convDone || stopMode) begin
         sarTrialCode <= 8'h80;
      end else if (state_r == SEQ_CONVERT && adcTick && trialBit != 8'h00) begin
         // Keep bit if input at or above trial; saturates at all ones
         sarTrialCode <= (comparatorHigh ? sarTrialCode : (sarTrialCode & ~trialBit))
                         | (trialBit >> 1);
      end
   end

   // Result updated every completion, overwritten regardless of reads
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         result_r <= RESULT_RESET;
      end else if (convDone) begin
         if (channel == HIGH_REF_CHANNEL) begin
            result_r <= FULL_SCALE_CODE;
         end else if (channel == LOW_REF_CHANNEL) begin
            result_r <= ZERO_SCALE_CODE;
         end else if (externalSel) begin
            result_r <= sarTrialCode;
         end else begin
            // Reserved codes read as zero scale, a defined value
            result_r <= ZERO_SCALE_CODE;
         end
      end
   end

   // Clock configuration and port registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         clockConfig_r <= CLOCK_CONFIG_RESET;
         portData_r    <= 6'h00;
         portDir_r     <= 6'h00;
      end else if (writeFire) begin
         if (awAddr_r == CLOCK_CONFIG_OFFSET && wStrb_r[0]) begin
            clockConfig_r <= wData_r[7:0];
         end
         if (awAddr_r == PORT_DATA_OFFSET) begin
            // Converter pin bits are discarded
            if (wStrb_r[0]) begin
               portData_r <= (wData_r[5:0] & ~pinOwned) | (portData_r & pinOwned);
            end
            if (wStrb_r[1]) begin
               portDir_r <= (wData_r[13:8] & ~pinOwned) | (portDir_r & pinOwned);
            end
         end
      end
   end

   // Pin ownership: only the selected external channel is taken over, and none while in stop
   for (genvar gi = 0; gi < EXTERNAL_CHANNELS; gi++) begin : g_pin
      assign pinOwned[gi] = (channel == 5'(gi)) && !stopMode;
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            sharedAnalogPinsOut[gi] <= 1'b0;
            sharedAnalogPinsOe[gi]  <= 1'b0;
         end else begin
            sharedAnalogPinsOut[gi] <= portData_r[gi];
            sharedAnalogPinsOe[gi]  <= portDir_r[gi] && !pinOwned[gi];
         end
      end
   end

   // Analog front end drive
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         muxSelect     <= POWER_OFF_CHANNEL;
         analogPowerOn <= 1'b0;
      end else begin
         muxSelect     <= channel;
         analogPowerOn <= !powerOff && !stopMode;
      end
   end

   // Read channel; a result read clears completion and interrupt
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
               STATUS_CONTROL_OFFSET:
                  s_axi_rdata <= {24'h000000, doneFlag_r, statusControl_r[6:0]};
               RESULT_OFFSET:
                  s_axi_rdata <= {24'h000000, result_r};
               CLOCK_CONFIG_OFFSET:
                  s_axi_rdata <= {24'h000000, clockConfig_r};
               // Converter pin reads zero
               PORT_DATA_OFFSET:
                  s_axi_rdata <= {18'h00000, portDir_r, 2'b00,
                                  sharedAnalogPinsIn & ~pinOwned};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

//--- dv/analog_front_model.sv
// Analog front end and shared pin model facing the converter sequencer
`timescale 1ns/1ps
module analog_front_model
   import sar_adc_pkg::*;
(
   // Clock
   input  wire logic       mclk,
   // Bench stimulus
   input  wire logic [7:0] analogLevel,
   input  wire logic [5:0] extLevel,
   // Converter side
   input  wire logic [7:0] sarTrialCode,
   input  wire logic [4:0] muxSelect,
   input  wire logic [5:0] sharedAnalogPinsOut,
   input  wire logic [5:0] sharedAnalogPinsOe,
   output logic            comparatorHigh,
   output logic [5:0]      sharedAnalogPinsIn,
   output logic            oscillatorTick
);
   logic [7:0] level;
   // References pin the input to full or zero scale
   always_comb begin
      level = analogLevel;
      if (muxSelect == HIGH_REF_CHANNEL) level = FULL_SCALE_CODE;
      if (muxSelect == LOW_REF_CHANNEL) level = ZERO_SCALE_CODE;
   end
   // Comparator answers against the live trial code, no settling help
   assign comparatorHigh = level >= sarTrialCode;
   // Pin level from whoever drives it
   assign sharedAnalogPinsIn = (sharedAnalogPinsOe & sharedAnalogPinsOut)
                             | (~sharedAnalogPinsOe & extLevel);
   // Oscillator at half the bus rate
   initial oscillatorTick = 1'b0;
   always @(posedge mclk) oscillatorTick <= ~oscillatorTick;
endmodule

//--- dv/sar_adc_properties.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
module sar_adc_properties
   import sar_adc_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // Bus handshakes
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Converter outputs
   input wire logic        stopMode,
   input wire logic [4:0]  muxSelect,
   input wire logic        analogPowerOn,
   input wire logic [5:0]  sharedAnalogPinsOe,
   input wire logic        convIrq,
   input wire logic        dmaRequest
);
   logic [3:0] wrAddr_r;
   logic [3:0] rdAddr_r;
   logic [4:0] since_r;
   logic       ctrlWr;
   logic       resRd;
   // Addresses of the transfers in flight
   always_ff @(posedge mclk) begin
      if (s_axi_awvalid && s_axi_awready) wrAddr_r <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) rdAddr_r <= s_axi_araddr;
   end
   assign ctrlWr = s_axi_bvalid && s_axi_bready && wrAddr_r == STATUS_CONTROL_OFFSET;
   assign resRd = s_axi_rvalid && s_axi_rready && rdAddr_r == RESULT_OFFSET;
   // Cycles since last control write; saturates so long idles stay legal
   always_ff @(posedge mclk) begin
      if (sys_rst) since_r <= 5'h1F;
      else if (ctrlWr) since_r <= 5'h00;
      else if (since_r != 5'h1F) since_r <= since_r + 5'h01;
   end

   AST_RESET_QUIET: assert property (@(posedge mclk) sys_rst |=>
      muxSelect == POWER_OFF_CHANNEL && !convIrq && !dmaRequest && !analogPowerOn)
      else $error("outputs not idle after reset");
   AST_MIN_TIME: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(convIrq || dmaRequest) |-> since_r >= 5'h0C) else $error("conversion too short");
   AST_READ_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
      resRd |-> ##[1:2] (!convIrq && !dmaRequest)) else $error("request kept after read");
   AST_WRITE_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
      ctrlWr |-> ##[0:1] (!convIrq && !dmaRequest)) else $error("request kept after write");
   AST_POWER_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
      muxSelect == POWER_OFF_CHANNEL && $stable(muxSelect) |-> !analogPowerOn)
      else $error("powered with off code");
   AST_PIN_INPUT: assert property (@(posedge mclk) disable iff (sys_rst)
      analogPowerOn && $past(analogPowerOn) && !stopMode && $stable(muxSelect)
      && muxSelect <= LAST_EXTERNAL_CHANNEL |-> !sharedAnalogPinsOe[muxSelect[2:0]])
      else $error("converter pin driven");
   AST_ROUTE_EXCL: assert property (@(posedge mclk) disable iff (sys_rst)
      convIrq |-> !dmaRequest) else $error("both routes active");
   AST_STOP_ABORT: assert property (@(posedge mclk) disable iff (sys_rst)
      stopMode [*3] |-> !$rose(convIrq) && !$rose(dmaRequest))
      else $error("completion during stop");
   AST_PORT_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
      s_axi_rvalid && rdAddr_r == PORT_DATA_OFFSET && analogPowerOn && !stopMode
      && muxSelect <= LAST_EXTERNAL_CHANNEL |-> !s_axi_rdata[muxSelect[2:0]])
      else $error("converter pin read nonzero");
endmodule

bind sar_adc_sequencer sar_adc_properties sar_adc_properties_inst (.*);

//--- dv/tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
   import sar_adc_pkg::*;
   localparam logic [3:0] CTL = STATUS_CONTROL_OFFSET;
   localparam logic [3:0] RES = RESULT_OFFSET;
   localparam logic [3:0] CKC = CLOCK_CONFIG_OFFSET;
   localparam logic [3:0] PRT = PORT_DATA_OFFSET;
   // Stimulus and bus master signals
   logic mclk = 1'b0, sys_rst = 1'b1, stopMode = 1'b0;
   logic [7:0] analogLevel = 8'h00;
   logic [5:0] extLevel = 6'h15;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   // Outputs of design and model
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic comparatorHigh, oscillatorTick, analogPowerOn, convIrq, dmaRequest;
   logic [7:0] sarTrialCode;
   logic [4:0] muxSelect;
   logic [5:0] sharedAnalogPinsIn, sharedAnalogPinsOut, sharedAnalogPinsOe;
   // Bookkeeping
   int mismatches = 0, compares = 0, seed = 94, i;
   logic [31:0] expQ[$], mskQ[$], expV, mskV;
   logic [4:0] ch;
   logic [5:0] pinBit;
   logic [7:0] ev;

   sar_adc_sequencer sar_adc_sequencer_inst (.*);
   analog_front_model analog_front_model_inst (.*);

   always #5 mclk = ~mclk;

   // Verdict and end of run
   task automatic complete_run;
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Bus write; each channel released once taken, bready held until bvalid
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 100);
   endtask

   // Bus read; expectation queued for the monitor
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFF);
      int n;
      n = 0;
      expQ.push_back(e);
      mskQ.push_back(m);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 100);
   endtask

   // Read answers against the oldest expectation
   always @(posedge mclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         expV = expQ.pop_front();
         mskV = mskQ.pop_front();
         `CHK("rdata", expV & mskV, s_axi_rdata & mskV)
      end
   end

   // Watchdog well beyond the expected thousand or so cycles
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(CTL, 32'h1F);
      rd(CKC, 32'h00);
      wr(CKC, 16'h0010);
      rd(CKC, 32'h10);
      // Every external input and both references, single shots
      for (i = 0; i < 8; i++) begin
         ch = (i < 6) ? 5'(i) : 5'(i + 23);
         pinBit = (i < 6) ? 6'h01 << i : 6'h00;
         analogLevel <= 8'($random(seed));
         wr(CTL, {11'h000, ch});
         wr(PRT, 16'h3F2A);
         // Pin enables land one edge after the port write
         @(posedge mclk);
         `CHK("power", 1'b1, analogPowerOn)
         `CHK("oe", 6'h3F & ~pinBit, sharedAnalogPinsOe)
         rd(PRT, {26'h0, 6'h2A & ~pinBit}, 32'h3F);
         repeat (24) @(posedge mclk);
         ev = (i == 6) ? FULL_SCALE_CODE : (i == 7) ? ZERO_SCALE_CODE : analogLevel;
         rd(CTL, {24'h0, 3'h4, ch});
         rd(RES, {24'h0, ev});
         rd(CTL, {27'h0, ch});
      end
      repeat (40) @(posedge mclk);
      rd(CTL, 32'h1E);
      // Continuous sampling
      analogLevel <= 8'h5A;
      wr(CTL, 16'h0021);
      repeat (24) @(posedge mclk);
      rd(CTL, 32'hA1);
      analogLevel <= 8'hC3;
      repeat (40) @(posedge mclk);
      rd(RES, 32'hC3);
      repeat (24) @(posedge mclk);
      rd(CTL, 32'h21);
      wr(CTL, 16'h0001);
      repeat (24) @(posedge mclk);
      ev = analogLevel;
      analogLevel <= 8'h11;
      repeat (40) @(posedge mclk);
      rd(RES, {24'h0, ev});
      wr(CTL, 16'h000A);
      repeat (24) @(posedge mclk);
      rd(RES, 32'h00);
      // Interrupt routing; selector set on purpose against software rules
      wr(CTL, 16'h0042);
      repeat (24) @(posedge mclk);
      `CHK("irq", 1'b1, convIrq)
      `CHK("dma", 1'b0, dmaRequest)
      rd(RES, 32'h11);
      repeat (2) @(posedge mclk);
      `CHK("irq", 1'b0, convIrq)
      wr(CTL, 16'h00C2);
      repeat (24) @(posedge mclk);
      `CHK("dma", 1'b1, dmaRequest)
      `CHK("irq", 1'b0, convIrq)
      rd(CTL, 32'hC2);
      wr(CTL, 16'h0042);
      @(posedge mclk);
      `CHK("dma", 1'b0, dmaRequest)
      // Power off frees every pin
      wr(CTL, 16'h001F);
      repeat (2) @(posedge mclk);
      `CHK("power", 1'b0, analogPowerOn)
      `CHK("oe", 6'h3F, sharedAnalogPinsOe)
      // Stop aborts, then a rewrite mid-conversion restarts the count
      wr(CTL, 16'h0003);
      repeat (6) @(posedge mclk);
      stopMode <= 1'b1;
      repeat (40) @(posedge mclk);
      rd(CTL, 32'h03);
      stopMode <= 1'b0;
      wr(CTL, 16'h0003);
      repeat (8) @(posedge mclk);
      analogLevel <= 8'h3C;
      wr(CTL, 16'h0004);
      repeat (6) @(posedge mclk);
      rd(CTL, 32'h04);
      repeat (20) @(posedge mclk);
      rd(CTL, 32'h84);
      rd(RES, 32'h3C);
      // Oscillator source divided by 8
      wr(CKC, 16'h0060);
      wr(CTL, 16'h0002);
      repeat (200) @(posedge mclk);
      rd(CTL, 32'h02);
      repeat (100) @(posedge mclk);
      rd(CTL, 32'h82);
      // Second reset in mid-run
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(CTL, 32'h1F);
      repeat (4) @(posedge mclk);
      complete_run();
   end
endmodule
